// [swcs_pkg.sv]
/*
 * swcs_pkg: shared constants and types for the switching clock source
 * select block. Assumes a single 250 MHz system clock.
 */
package swcs_pkg;

    // system clock rate
    localparam int unsigned CLK_KHZ = 250000;
    localparam int unsigned CLK_MHZ = 250;

    // user_configuration field positions
    localparam int unsigned UCFG_MODE_LO   = 5;
    localparam int unsigned UCFG_MODE_HI   = 6;
    localparam int unsigned UCFG_HOLD_BIT  = 11;
    // manufacturer_configuration push/pull select
    localparam int unsigned MCFG_PP_BIT    = 0;
    // miscellaneous configuration precise ramp-up delay disable bit
    localparam int unsigned MISC_RAMP_BIT  = 7;

    // values after reset, and the pin function select code for the clock pin
    localparam logic [15:0] UCFG_RESET     = 16'h0000;
    localparam logic [15:0] MCFG_RESET     = 16'h0000;
    localparam logic [15:0] MISC_RESET     = 16'h0000;
    localparam logic [7:0]  PIN_SYNC_SEL   = 8'h00;

    // clock pin mode encodings of bits 6:5
    localparam logic [1:0]  MODE_AUTO      = 2'h0;
    localparam logic [1:0]  MODE_OUT       = 2'h1;
    localparam logic [1:0]  MODE_IN        = 2'h2;

    // clock output hold after disable
    localparam int unsigned HOLD_MS        = 500;
    localparam int unsigned HOLD_CYC       = HOLD_MS * CLK_KHZ;

    // clock presence detection window and edge count
    localparam int unsigned DETECT_US      = 10;
    localparam logic [11:0] DETECT_WIN_CYC = 12'(DETECT_US * CLK_MHZ);
    localparam logic [2:0]  DETECT_EDGES   = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DETECT,
        ST_LOCKED,
        ST_FREE,
        ST_STALLED,
        ST_HOLD
    } swcs_state_t;

    // pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } swcs_sync_t;

    // pin drive carrier
    typedef struct packed {
        logic out;
        logic oe;
    } swcs_pin_t;

endpackage

// [swcs_pin_sync.sv]
/*
 * swcs_pin_sync: three flop synchroniser with agreement filter and
 * rising edge pulse for the shared clock pin.
 * Assumes the pin is asynchronous to mclk.
 */
module swcs_pin_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    swcs_pkg::swcs_sync_t q;
    swcs_pkg::swcs_sync_t next_q;

    // level moves only when second and third stages agree
    always_comb
    begin
        next_q      = q;
        next_q.s1   = pin_in;
        next_q.s2   = q.s1;
        next_q.s3   = q.s2;
        next_q.rise = 1'b0;
        if (q.s2 == q.s3 && q.s3 != q.lvl)
        begin
            next_q.lvl  = q.s3;
            next_q.rise = q.s3;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            // start at the idle high level, so release makes no false rise
            q      <= '1;
            q.rise <= 1'b0;
        end
        else
            q <= next_q;
    end

    assign level = q.lvl;
    assign rise  = q.rise;
endmodule // swcs_pin_sync

// [swcs_clock_select.sv]
/*
 * swcs_clock_select: selects the switching clock source (external lock,
 * free-running oscillator, or driving the shared clock pin).
 * Assumes configuration words are held stable by the management bus
 * logic outside and presented as levels.
 */
// Functional notes
// - input mode: at enable, detect pin clock and lock oscillator to rises
// - output mode: run internal oscillator and drive it onto pin
// - pin driver push/pull or open drain per manufacturer bit 0
// - output mode never monitors the pin for a clock
// - auto mode: lock if clock found at enable, else free run
// - bits 6:5: 00 auto, 10 input, 01 output
// - output mode: bit 11 zero holds clock on; one holds 500 ms
// - precise ramp delay active: clock output always stays on after disable
// - pin is clock pin only when pin function is 0x00
// - pin used as clock pin is not used for voltage adjust
// - input mode with no clock: never switch
// - oscillator set from frequency command; readback quantised
module swcs_clock_select #(
    parameter logic [26:0] HOLD_CYCLES = 27'(swcs_pkg::HOLD_CYC)
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        regulator_enable,
    input  wire logic [15:0] user_configuration,
    input  wire logic [15:0] manufacturer_configuration,
    input  wire logic [15:0] misc_configuration,
    input  wire logic [7:0]  pin_function_select,
    input  wire logic [15:0] switching_frequency_khz,
    input  wire logic        sync_pin_in,
    output logic             sync_pin_out,
    output logic             sync_pin_oe,
    output logic             switch_clock,
    output logic             switching_active,
    output logic             clock_locked,
    output logic             voltage_adjust_enable,
    output logic [15:0]      frequency_readback_khz
);
    typedef struct packed {
        swcs_pkg::swcs_state_t st;
        logic [1:0]  mode;
        logic        pp;
        logic        sel;
        logic        timed;
        logic [15:0] half;
        logic [15:0] osc_cnt;
        logic        osc;
        logic [11:0] win_cnt;
        logic [2:0]  edge_cnt;
        logic [26:0] hold_cnt;
        swcs_pkg::swcs_pin_t pin;
        logic        sw_clk;
        logic        sw_run;
        logic        locked;
        logic        adj_en;
        logic [15:0] freq_rb;
    } swcs_main_t;

    swcs_main_t q;
    swcs_main_t next_q;
    logic       pin_rise;
    localparam logic [2:0]  DETECT_LAST = swcs_pkg::DETECT_EDGES - 3'h1;
    localparam logic [11:0] DETECT_END  = swcs_pkg::DETECT_WIN_CYC - 12'h001;

    // saturating divide, shared by period setting and readback
    function automatic logic [15:0] quant_div(input logic [31:0] num,
                                              input logic [31:0] den);
        logic [31:0] r;
        r = 32'h0000FFFF;
        if (den != 32'h00000000)
            r = num / den;
        if (r > 32'h0000FFFF)
            r = 32'h0000FFFF;
        return r[15:0];
    endfunction

    swcs_pin_sync u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .pin_in (sync_pin_in),
        .level  (),
        .rise   (pin_rise)
    );

    // decode, oscillator, source state machine and pin drive
    always_comb
    begin
        next_q = q;
        // decode mode; pin function other than clock forces internal
        next_q.sel = (pin_function_select == swcs_pkg::PIN_SYNC_SEL);
        next_q.mode = user_configuration[swcs_pkg::UCFG_MODE_HI -:
                                         2];
        if (next_q.mode != swcs_pkg::MODE_IN &&
            next_q.mode != swcs_pkg::MODE_OUT)
            next_q.mode = swcs_pkg::MODE_AUTO; // 11 treated as auto
        next_q.pp = manufacturer_configuration[swcs_pkg::MCFG_PP_BIT];
        // precise ramp delay overrides the hold bit
        next_q.timed = user_configuration[swcs_pkg::UCFG_HOLD_BIT] &&
                       misc_configuration[swcs_pkg::MISC_RAMP_BIT];
        next_q.adj_en = !next_q.sel;
        // oscillator half period and the frequency that it really gives
        next_q.half = quant_div(32'(swcs_pkg::CLK_KHZ),
                                {15'h0000, switching_frequency_khz,
                                 1'b0});
        if (next_q.half == 16'h0000)
            next_q.half = 16'h0001;
        next_q.freq_rb = quant_div(32'(swcs_pkg::CLK_KHZ),
                                   {15'h0000, q.half, 1'b0});

        case (q.st)
            swcs_pkg::ST_IDLE:
            begin
                next_q.hold_cnt = 27'h0000000;
                if (regulator_enable)
                begin
                    next_q.win_cnt  = 12'h000;
                    next_q.edge_cnt = 3'h0;
                    // output mode never looks at the pin
                    if (!next_q.sel ||
                        next_q.mode == swcs_pkg::MODE_OUT)
                        next_q.st = swcs_pkg::ST_FREE;
                    else
                        next_q.st = swcs_pkg::ST_DETECT;
                end
            end
            swcs_pkg::ST_DETECT:
            begin
                next_q.win_cnt = q.win_cnt + 12'h001;
                if (pin_rise && q.edge_cnt != DETECT_LAST)
                    next_q.edge_cnt = q.edge_cnt + 3'h1;
                if (!regulator_enable)
                    next_q.st = swcs_pkg::ST_IDLE;
                else if (!next_q.sel || next_q.mode == swcs_pkg::MODE_OUT)
                    next_q.st = swcs_pkg::ST_FREE;
                else if (pin_rise && q.edge_cnt == DETECT_LAST)
                    next_q.st = swcs_pkg::ST_LOCKED;
                else if (q.win_cnt == DETECT_END)
                    next_q.st = (q.mode == swcs_pkg::MODE_IN) ?
                                swcs_pkg::ST_STALLED :
                                swcs_pkg::ST_FREE;
            end
            swcs_pkg::ST_LOCKED, swcs_pkg::ST_FREE, swcs_pkg::ST_STALLED:
            begin
                // a disabled output-mode driver may keep the line alive
                if (!regulator_enable)
                    next_q.st = (q.sel && q.mode == swcs_pkg::MODE_OUT) ?
                                swcs_pkg::ST_HOLD : swcs_pkg::ST_IDLE;
            end
            swcs_pkg::ST_HOLD:
            begin
                if (regulator_enable)
                    next_q.st = swcs_pkg::ST_FREE;
                else if (!q.sel || q.mode != swcs_pkg::MODE_OUT)
                    next_q.st = swcs_pkg::ST_IDLE;
                else if (q.timed)
                begin
                    next_q.hold_cnt = q.hold_cnt + 27'h0000001;
                    if (q.hold_cnt == HOLD_CYCLES - 27'h0000001)
                        next_q.st = swcs_pkg::ST_IDLE;
                end
                else
                    next_q.hold_cnt = 27'h0000000; // runs on
            end
            default:
                next_q.st = swcs_pkg::ST_IDLE;
        endcase

        // oscillator: free running, or phase reset on each pin rise
        if (next_q.st == swcs_pkg::ST_LOCKED ||
            next_q.st == swcs_pkg::ST_FREE ||
            next_q.st == swcs_pkg::ST_HOLD)
        begin
            if (q.st == swcs_pkg::ST_LOCKED && pin_rise)
            begin
                next_q.osc     = 1'b1;
                next_q.osc_cnt = 16'h0000;
            end
            else if (q.osc_cnt >= q.half - 16'h0001)
            begin
                next_q.osc     = !q.osc;
                next_q.osc_cnt = 16'h0000;
            end
            else
                next_q.osc_cnt = q.osc_cnt + 16'h0001;
        end
        else
        begin
            next_q.osc     = 1'b0;
            next_q.osc_cnt = 16'h0000;
        end

        next_q.locked = (next_q.st == swcs_pkg::ST_LOCKED);
        // stalled input mode holds off switching
        next_q.sw_run = (next_q.st == swcs_pkg::ST_LOCKED ||
                         next_q.st == swcs_pkg::ST_FREE);
        next_q.sw_clk = next_q.sw_run && next_q.osc;

        // pin driver; open drain only pulls the low phase
        next_q.pin = '0;
        if (next_q.sel && next_q.mode == swcs_pkg::MODE_OUT &&
            (next_q.st == swcs_pkg::ST_FREE ||
             next_q.st == swcs_pkg::ST_HOLD))
        begin
            if (next_q.pp)
            begin
                next_q.pin.out = next_q.osc;
                next_q.pin.oe  = 1'b1;
            end
            else
            begin
                next_q.pin.out = 1'b0;
                next_q.pin.oe  = !next_q.osc;
            end
        end
    end

    // one register stage holds all state outside the pin synchroniser
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            q        <= '0;
            q.st     <= swcs_pkg::ST_IDLE;
            q.sel    <= 1'b1;
            q.half   <= 16'h0001;
            q.adj_en <= 1'b0;
        end
        else
            q <= next_q;
    end

    assign sync_pin_out           = q.pin.out;
    assign sync_pin_oe            = q.pin.oe;
    assign switch_clock           = q.sw_clk;
    assign switching_active       = q.sw_run;
    assign clock_locked           = q.locked;
    assign voltage_adjust_enable  = q.adj_en;
    assign frequency_readback_khz = q.freq_rb;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_out_no_detect: assert property (
        (q.sel && q.mode == swcs_pkg::MODE_OUT) |-> q.st != swcs_pkg::ST_DETECT)
        else $error("output mode entered detection");
    chk_lock_rise: assert property (
        (q.st == swcs_pkg::ST_LOCKED && pin_rise && regulator_enable)
        |=> (q.osc && q.osc_cnt == 16'h0000))
        else $error("oscillator not aligned to pin rise");
    chk_pp_drive: assert property (
        (q.sel && q.mode == swcs_pkg::MODE_OUT && q.pp &&
         q.st == swcs_pkg::ST_FREE) |-> (sync_pin_oe && sync_pin_out == q.osc))
        else $error("push pull drive wrong");
    chk_od_drive: assert property (
        (q.sel && q.mode == swcs_pkg::MODE_OUT && !q.pp &&
         q.st == swcs_pkg::ST_HOLD) |-> (!sync_pin_out && sync_pin_oe == !q.osc))
        else $error("open drain drive wrong");
    chk_stall_quiet: assert property (
        q.st == swcs_pkg::ST_STALLED |-> (!switching_active && !switch_clock))
        else $error("switching while stalled");
    chk_pin_internal: assert property (
        !q.sel |-> (!sync_pin_oe && q.st != swcs_pkg::ST_DETECT))
        else $error("pin used while not a clock pin");
    chk_sel_no_adjust: assert property (
        q.sel |-> !voltage_adjust_enable)
        else $error("voltage adjust on clock pin");
    chk_hold_expire: assert property (
        (q.st == swcs_pkg::ST_HOLD && q.timed && !regulator_enable &&
         q.sel && q.mode == swcs_pkg::MODE_OUT &&
         q.hold_cnt == HOLD_CYCLES - 27'h0000001)
        |=> (q.st == swcs_pkg::ST_IDLE ##1 !sync_pin_oe))
        else $error("hold did not end on time");
    chk_hold_forever: assert property (
        (q.st == swcs_pkg::ST_HOLD && !q.timed && !regulator_enable &&
         q.sel && q.mode == swcs_pkg::MODE_OUT) |-> q.hold_cnt == 27'h0000000)
        else $error("hold counted while untimed");
    chk_auto_free: assert property (
        (q.st == swcs_pkg::ST_DETECT && regulator_enable && !pin_rise &&
         q.mode == swcs_pkg::MODE_AUTO && q.win_cnt == DETECT_END)
        |=> q.st == swcs_pkg::ST_FREE)
        else $error("auto mode did not free run");
    chk_detect_window: assert property (
        q.st == swcs_pkg::ST_DETECT |-> q.win_cnt <= DETECT_END)
        else $error("detection window overrun");

    cov_locked: cover property (q.st == swcs_pkg::ST_DETECT
                                ##1 q.st == swcs_pkg::ST_LOCKED);
    cov_stalled: cover property (q.st == swcs_pkg::ST_STALLED);
    cov_hold_end: cover property (q.st == swcs_pkg::ST_HOLD
                                  ##1 q.st == swcs_pkg::ST_IDLE);
endmodule // swcs_clock_select

// [swcs_peer_clock.sv]
/*
 * swcs_peer_clock: behavioural external clock source, or a peer
 * regulator that drives the shared clock line.
 * Assumes a pull-up on the line; the bench resolves the wire level.
 */
module swcs_peer_clock #(
    parameter real HALF_NS = 20.0
) (
    input  wire logic run,
    output logic      clk_out,
    output logic      drive
);
    timeunit 1ns;
    timeprecision 1ps;

    // runs only while asked, then stops and lets the pull-up win
    initial
    begin
        clk_out = 1'b0;
        drive   = 1'b0;
        forever
        begin
            wait (run);
            drive = 1'b1;
            #(1.3); // phase unrelated to mclk
            while (run)
            begin
                clk_out = ~clk_out;
                #(HALF_NS);
            end
            drive   = 1'b0;
            clk_out = 1'b0;
        end
    end
endmodule // swcs_peer_clock

// [testbench.sv]
/*
 * testbench: self-checking bench for swcs_clock_select.
 * Assumes the peer clock model and a pull-up on the shared clock line.
 */
`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %h seen %h", nm, e, g); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [26:0] HOLD  = 27'h32; // short hold keeps runs brief
    localparam int          LIMIT = 20000;
    logic        mclk, rst, en, ext_run, ext_clk, ext_drv, line;
    logic [15:0] ucfg, mcfg, misc, freq, rdbk;
    logic [7:0]  pfs;
    logic        pin_out, pin_oe, sw_clk, sw_act, locked, vadj;
    int          n_fail, checks_done, cyc;

    // wired line: device drive wins, else peer, else pull-up
    assign line = pin_oe ? pin_out : (ext_drv ? ext_clk : 1'b1);

    swcs_clock_select #(.HOLD_CYCLES(HOLD)) i_dut (
        .mclk(mclk), .rst(rst), .regulator_enable(en),
        .user_configuration(ucfg), .manufacturer_configuration(mcfg),
        .misc_configuration(misc), .pin_function_select(pfs),
        .switching_frequency_khz(freq), .sync_pin_in(line),
        .sync_pin_out(pin_out), .sync_pin_oe(pin_oe),
        .switch_clock(sw_clk), .switching_active(sw_act),
        .clock_locked(locked), .voltage_adjust_enable(vadj),
        .frequency_readback_khz(rdbk)
    );

    swcs_peer_clock #(.HALF_NS(20.0)) i_peer (
        .run(ext_run), .clk_out(ext_clk), .drive(ext_drv)
    );

    // clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // fresh reset with a configuration; peer stopped, 25 MHz command
    task automatic start(input logic [15:0] u, m, x, input logic [7:0] p);
        @(negedge mclk);
        {rst, en, ext_run} = 3'h4;
        {ucfg, mcfg, misc, pfs} = {u, m, x, p};
        freq = 16'h61A8;
        cycles(8);
        rst = 1'b0;
        cycles(2);
    endtask

    task automatic count_tog(input int n, output int t_o, output int t_e);
        logic po, pe;
        {t_o, t_e, po, pe} = {32'h0, 32'h0, pin_out, pin_oe};
        repeat (n)
        begin
            @(negedge mclk);
            t_o += int'(pin_out !== po);
            t_e += int'(pin_oe !== pe);
            {po, pe} = {pin_out, pin_oe};
        end
    endtask

    task automatic wait_lock();
        int k;
        k = 0;
        while (locked !== 1'b1 && k < 2600)
        begin
            @(negedge mclk);
            k++;
        end
    endtask

    task automatic t_pin_func();
        start(16'h0040, 16'h0000, 16'h0000, 8'h00);
        `CHK("vadj clock pin", 1'b0, vadj);
        pfs = 8'h01;
        ext_run = 1'b1;
        cycles(20);
        en = 1'b1;
        cycles(60);
        `CHK("vadj free pin", 1'b1, vadj);
        `CHK("locked", 1'b0, locked);
        `CHK("active", 1'b1, sw_act);
        `CHK("oe", 1'b0, pin_oe);
        $display("done: pin function");
    endtask

    task automatic t_push_pull();
        int a, b;
        start(16'h0820, 16'h0001, 16'h0000, 8'h00);
        freq = 16'h5DC0; // 24000 kHz quantises to 25000
        en = 1'b1;
        cycles(10);
        `CHK("oe", 1'b1, pin_oe);
        `CHK("active", 1'b1, sw_act);
        `CHK("locked", 1'b0, locked);
        `CHK("readback", 16'h61A8, rdbk);
        count_tog(100, a, b);
        `CHK("out toggles", 1'b1, (a >= 19 && a <= 21));
        `CHK("oe toggles", 0, b);
        a = int'(sw_clk);
        cycles(5);
        `CHK("switch clock half period", !a[0], sw_clk);
        en = 1'b0;
        cycles(int'(HOLD) + 20);
        `CHK("oe held", 1'b1, pin_oe);
        `CHK("active off", 1'b0, sw_act);
        $display("done: push pull");
    endtask

    task automatic t_open_drain();
        int a, b;
        start(16'h0020, 16'h0000, 16'h0000, 8'h00);
        en = 1'b1;
        cycles(10);
        count_tog(100, a, b);
        `CHK("out level", 1'b0, pin_out);
        `CHK("out toggles", 0, a);
        `CHK("oe toggles", 1'b1, (b >= 19 && b <= 21));
        // open drain keeps pulsing the line while held after disable
        en = 1'b0;
        cycles(5);
        count_tog(50, a, b);
        `CHK("oe toggles in hold", 1'b1, (b >= 9 && b <= 11));
        $display("done: open drain");
    endtask

    // timed hold stops after HOLD cycles only with bit 11 set
    task automatic t_hold();
        for (int b = 0; b < 2; b++)
        begin
            start(b ? 16'h0820 : 16'h0020, 16'h0001, 16'h0080, 8'h00);
            en = 1'b1;
            cycles(10);
            en = 1'b0;
            cycles(int'(HOLD) - 10);
            `CHK("oe in hold", 1'b1, pin_oe);
            cycles(25);
            `CHK("oe after hold", b ? 1'b0 : 1'b1, pin_oe);
        end
        $display("done: hold");
    endtask

    task automatic t_lock();
        for (int m = 0; m < 2; m++)
        begin
            start(m ? 16'h0000 : 16'h0040, 16'h0001, 16'h0000, 8'h00);
            ext_run = 1'b1;
            cycles(20);
            en = 1'b1;
            cycles(15);
            `CHK("early lock", 1'b0, locked);
            wait_lock();
            `CHK("locked", 1'b1, locked);
            `CHK("active", 1'b1, sw_act);
            `CHK("oe", 1'b0, pin_oe);
            // let further rises re-align the locked oscillator
            cycles(30);
            `CHK("still locked", 1'b1, locked);
        end
        $display("done: lock");
    endtask

    task automatic t_absent();
        for (int m = 0; m < 2; m++)
        begin
            // mode 11 must behave as auto
            start(m ? 16'h0060 : 16'h0040, 16'h0000, 16'h0000, 8'h00);
            en = 1'b1;
            cycles(2700);
            `CHK("locked", 1'b0, locked);
            `CHK("active", m ? 1'b1 : 1'b0, sw_act);
        end
        $display("done: absent clock");
    endtask

    // main sequence
    initial
    begin
        {n_fail, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
        {rst, en, ext_run, ucfg, mcfg, misc} = {3'h4, 48'h0};
        {pfs, freq} = {8'h00, 16'h61A8};
        t_pin_func();
        t_push_pull();
        t_open_drain();
        t_hold();
        t_lock();
        t_absent();
        end_of_test();
    end
endmodule // testbench
